/* File: core/pdt_pkg.sv */
// Constants shared by the delay timer and up/down counter block
package pdt_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ    = 50_000_000;
    localparam int unsigned TICK_TIME_NS  = 100_000;
    localparam int unsigned TICK_CYC      = (SYS_CLK_HZ / 1_000_000) * TICK_TIME_NS / 1_000;

    // ------------------------------------------------------------
    // Value ranges
    // ------------------------------------------------------------
    localparam int unsigned TMR_W         = 16;
    localparam logic [15:0] TMR_PRESET_MAX = 16'hFFEF;
    localparam int unsigned CNT_PRESET_W  = 24;
    localparam logic [23:0] CNT_PRESET_MAX = 24'h98967F;
    localparam int unsigned CNT_W         = 26;

    // ------------------------------------------------------------
    // Signal ranges (O,I,N,P,X,M,V,S)
    // ------------------------------------------------------------
    localparam int unsigned RANGE_NUM     = 8;
    localparam int unsigned RANGE_CODE_W  = 3;
    localparam logic [2:0]  RANGE_MARKER  = 3'h5;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_TMR_PRE   = 8'h04;
    localparam logic [7:0]  OFS_CNT_PRE   = 8'h08;
    localparam logic [7:0]  OFS_SEL       = 8'h0C;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [7:0]  OFS_COUNT     = 8'h14;
    localparam logic [7:0]  OFS_CNT_CLR   = 8'h18;

    // CTRL fields
    localparam int unsigned CTRL_DOWN_BIT = 0;
    localparam int unsigned CTRL_FALL_BIT = 1;
    // SEL fields: second condition in [15:0], reset in [31:16]
    localparam int unsigned SEL_IDX_LSB   = 0;
    localparam int unsigned SEL_CODE_LSB  = 12;
    localparam int unsigned SEL_RST_LSB   = 16;

    // Reset values
    localparam logic [1:0]  CTRL_RST      = 2'h0;
    localparam logic [15:0] TMR_PRE_RST   = 16'h0000;
    localparam logic [23:0] CNT_PRE_RST   = 24'h000000;
    localparam logic [31:0] SEL_RST       = 32'h00000000;

endpackage

/* File: core/pdt_top.sv */
// On-delay, latching off-delay timers and four-variant up/down counter
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - On-delay output rises once preset time elapses after result rising edge.
// - On-delay output drops as soon as the result goes false.
// - Result false before expiry abandons timing; output stays low.
// - Off-delay output sets immediately on result rising edge.
// - Result falling edge starts time; off-delay output clears at expiry.
// - Timer preset spans 0.0 to 6551.9 ms in 0.1 ms steps.
// - Counter runs up or down, on rising or falling edges.
// - Counter has primary input, opposite second input and reset input.
// - Rising-edge up-counter adds one per primary rising edge.
// - Up-counter output asserts when increment reaches preset.
// - Up-counter subtracts one per qualifying second-condition edge.
// - Up-counter reset clears count to zero and drops output.
// - Falling-edge up-counter counts both inputs on falling edges.
// - Rising-edge down-counter subtracts one per primary rising edge.
// - Down-counter output asserts when decrement reaches zero.
// - Down-counter adds one per qualifying second-condition edge.
// - Down-counter reset reloads starting value and drops output.
// - Falling-edge down-counter counts both inputs on falling edges.
// - Counter preset accepts 0 to 9999999.
// - Second input may pass zero or preset and leaves final value.
// - Second condition selected from any signal range by code and index.
// - Counter reset selected from any signal range by code and index.
// - Marker-range counters may keep their count through power loss.
module pdt_top #(
    parameter int unsigned TICK_CYCLES = pdt_pkg::TICK_CYC,
    parameter int unsigned IDX_W       = 8,
    parameter bit          RETAIN_CNT  = 1'b0
) (
    input  wire logic                                     sys_clk,
    input  wire logic                                     srst,
    input  wire logic                                     scan_en,
    input  wire logic                                     on_lr,
    input  wire logic                                     off_lr,
    input  wire logic                                     cnt_lr,
    input  wire logic [pdt_pkg::RANGE_NUM*(2**IDX_W)-1:0] sig_ranges,
    input  wire logic [pdt_pkg::ADDR_W-1:0]               reg_addr,
    input  wire logic [31:0]                              reg_wdata,
    input  wire logic                                     reg_wr,
    input  wire logic                                     reg_rd,
    output logic      [31:0]                              reg_rdata,
    output logic                                          on_delay_timer_out,
    output logic                                          latching_off_delay_timer_out,
    output logic                                          cnt_out
);

    localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic sel_bit(input logic [15:0] sel,
                                     input logic [pdt_pkg::RANGE_NUM*(2**IDX_W)-1:0] vec);
        logic [pdt_pkg::RANGE_CODE_W-1:0] code;
        logic [IDX_W-1:0]                 idx;
        code = sel[pdt_pkg::SEL_CODE_LSB +: pdt_pkg::RANGE_CODE_W];
        idx  = sel[pdt_pkg::SEL_IDX_LSB +: IDX_W];
        sel_bit = vec[{code, idx}];
    endfunction

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] max);
        clamp = (v > max) ? max : v;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0]                        ctrl_r;
    logic [pdt_pkg::TMR_W-1:0]         tmr_pre_r;
    logic [pdt_pkg::CNT_PRESET_W-1:0]  cnt_pre_r;
    logic [31:0]                       sel_r;
    logic                              man_clr_r;
    logic [31:0]                       reg_rdata_r;
    logic signed [pdt_pkg::CNT_W-1:0]  count_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl_r    <= pdt_pkg::CTRL_RST;
            tmr_pre_r <= pdt_pkg::TMR_PRE_RST;
            cnt_pre_r <= pdt_pkg::CNT_PRE_RST;
            sel_r     <= pdt_pkg::SEL_RST;
            man_clr_r <= 1'b0;
        end
        else
        begin
            man_clr_r <= reg_wr && (reg_addr == pdt_pkg::OFS_CNT_CLR);
            if (reg_wr)
            begin
                case (reg_addr)
                    pdt_pkg::OFS_CTRL:    ctrl_r    <= reg_wdata[1:0];
                    pdt_pkg::OFS_TMR_PRE: tmr_pre_r <= 16'(clamp(reg_wdata, 32'(pdt_pkg::TMR_PRESET_MAX)));
                    pdt_pkg::OFS_CNT_PRE: cnt_pre_r <= 24'(clamp(reg_wdata, 32'(pdt_pkg::CNT_PRESET_MAX)));
                    pdt_pkg::OFS_SEL:     sel_r     <= reg_wdata;
                    default:              ;
                endcase
            end
        end
    end

    // Read data valid exactly one cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata_r <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                pdt_pkg::OFS_CTRL:    reg_rdata_r <= {30'h0, ctrl_r};
                pdt_pkg::OFS_TMR_PRE: reg_rdata_r <= {16'h0, tmr_pre_r};
                pdt_pkg::OFS_CNT_PRE: reg_rdata_r <= {8'h0, cnt_pre_r};
                pdt_pkg::OFS_SEL:     reg_rdata_r <= sel_r;
                pdt_pkg::OFS_STATUS:  reg_rdata_r <= {29'h0, cnt_out, latching_off_delay_timer_out,
                                                      on_delay_timer_out};
                pdt_pkg::OFS_COUNT:   reg_rdata_r <= 32'(count_r);
                default:              reg_rdata_r <= 32'h00000000;
            endcase
        end
        else
            reg_rdata_r <= 32'h00000000;
    end

    assign reg_rdata = reg_rdata_r;

    // ------------------------------------------------------------
    // 0.1 ms time base
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_r;
    logic              tick_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r == TICK_LAST)
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + TICK_W'(1);
            tick_r     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Scan-cycle edge capture
    // ------------------------------------------------------------
    logic on_prev_r;
    logic off_prev_r;
    logic cnt_prev_r;
    logic sec_prev_r;
    logic sec_now;
    logic rst_now;

    assign sec_now = sel_bit(sel_r[15:0], sig_ranges);
    assign rst_now = sel_bit(sel_r[31:pdt_pkg::SEL_RST_LSB], sig_ranges);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            on_prev_r  <= 1'b0;
            off_prev_r <= 1'b0;
            cnt_prev_r <= 1'b0;
            sec_prev_r <= 1'b0;
        end
        else if (scan_en)
        begin
            on_prev_r  <= on_lr;
            off_prev_r <= off_lr;
            cnt_prev_r <= cnt_lr;
            sec_prev_r <= sec_now;
        end
    end

    logic on_rise;
    logic off_rise;
    logic off_fall;
    assign on_rise  = scan_en && on_lr && !on_prev_r;
    assign off_rise = scan_en && off_lr && !off_prev_r;
    assign off_fall = scan_en && !off_lr && off_prev_r;

    // ------------------------------------------------------------
    // On-delay timer
    // ------------------------------------------------------------
    logic                      on_run_r;
    logic [pdt_pkg::TMR_W-1:0] on_tmr_r;
    logic                      on_out_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            on_run_r <= 1'b0;
            on_tmr_r <= '0;
            on_out_r <= 1'b0;
        end
        else if (scan_en && !on_lr)
        begin
            on_run_r <= 1'b0;
            on_out_r <= 1'b0;
        end
        else if (on_rise)
        begin
            on_run_r <= 1'b1;
            on_tmr_r <= '0;
            on_out_r <= 1'b0;
        end
        else
        begin
            if (on_run_r && tick_r && on_tmr_r < tmr_pre_r)
                on_tmr_r <= on_tmr_r + 16'h0001;
            if (scan_en && on_run_r && on_tmr_r >= tmr_pre_r)
                on_out_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Latching off-delay timer
    // ------------------------------------------------------------
    logic                      off_run_r;
    logic [pdt_pkg::TMR_W-1:0] off_tmr_r;
    logic                      off_out_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            off_run_r <= 1'b0;
            off_tmr_r <= '0;
            off_out_r <= 1'b0;
        end
        else if (off_rise)
        begin
            off_run_r <= 1'b0;
            off_out_r <= 1'b1;
        end
        else if (off_fall)
        begin
            off_run_r <= 1'b1;
            off_tmr_r <= '0;
        end
        else
        begin
            if (off_run_r && tick_r && off_tmr_r < tmr_pre_r)
                off_tmr_r <= off_tmr_r + 16'h0001;
            if (scan_en && off_run_r && off_tmr_r >= tmr_pre_r)
            begin
                off_run_r <= 1'b0;
                off_out_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Up/down counter
    // ------------------------------------------------------------
    logic cnt_down;
    logic cnt_fall;
    logic pri_edge;
    logic sec_edge;
    logic cnt_out_r;
    logic signed [pdt_pkg::CNT_W-1:0] pre_s;
    logic signed [pdt_pkg::CNT_W-1:0] count_nxt;

    assign cnt_down = ctrl_r[pdt_pkg::CTRL_DOWN_BIT];
    assign cnt_fall = ctrl_r[pdt_pkg::CTRL_FALL_BIT];
    // Edge polarity follows the variant for both inputs
    assign pri_edge = scan_en &&
                      (cnt_fall ? (!cnt_lr && cnt_prev_r) : (cnt_lr && !cnt_prev_r));
    assign sec_edge = scan_en && (cnt_fall ? (!sec_now && sec_prev_r) : (sec_now && !sec_prev_r));
    assign pre_s    = $signed({2'b00, cnt_pre_r});

    always_comb
    begin
        count_nxt = count_r;
        if (pri_edge && !sec_edge)
            count_nxt = cnt_down ? count_r - 26'sd1 : count_r + 26'sd1;
        else if (sec_edge && !pri_edge)
            count_nxt = cnt_down ? count_r + 26'sd1 : count_r - 26'sd1;
    end

    // Retention only modelled as surviving srst, since marker counters sit in backed-up store
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            if (!(RETAIN_CNT && sel_r[pdt_pkg::SEL_RST_LSB + pdt_pkg::SEL_CODE_LSB +: 3] == pdt_pkg::RANGE_MARKER))
                count_r <= '0;
            cnt_out_r <= 1'b0;
        end
        else if ((scan_en && rst_now) || man_clr_r)
        begin
            count_r   <= cnt_down ? pre_s : '0;
            cnt_out_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            if (pri_edge && !sec_edge)
                cnt_out_r <= cnt_down ? (count_nxt <= 0) : (count_nxt >= pre_s);
            else if (sec_edge && !pri_edge)
                cnt_out_r <= 1'b0;
        end
    end

    assign on_delay_timer_out           = on_out_r;
    assign latching_off_delay_timer_out = off_out_r;
    assign cnt_out                      = cnt_out_r;

endmodule // pdt_top

/* File: sim/pdt_checker_assertions.sv */
// Concurrent checks on the timer and counter outputs
`timescale 1ns/1ps
module pdt_checker #(
    parameter int unsigned IDX_W = 8,
    localparam int unsigned SIG_W = pdt_pkg::RANGE_NUM * (2 ** IDX_W)
) (
    input wire logic             sys_clk,
    input wire logic             srst,
    input wire logic             scan_en,
    input wire logic             on_lr,
    input wire logic             off_lr,
    input wire logic             cnt_lr,
    input wire logic [SIG_W-1:0] sig_ranges,
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [31:0]      reg_rdata,
    input wire logic             on_delay_timer_out,
    input wire logic             latching_off_delay_timer_out,
    input wire logic             cnt_out
);
    logic [31:0] sel_r;
    logic        fall_r, on_q_r, pri_q_r, sec_q_r;
    logic        sec_now, rst_now, pri_edge, sec_edge;

    // ------------------------------------------------------------
    // Shadow of selection and previous-scan values
    // ------------------------------------------------------------
    assign sec_now  = sig_ranges[{sel_r[14:12], sel_r[IDX_W-1:0]}];
    assign rst_now  = sig_ranges[{sel_r[30:28], sel_r[16+:IDX_W]}];
    assign pri_edge = fall_r ? (pri_q_r & ~cnt_lr) : (~pri_q_r & cnt_lr);
    assign sec_edge = fall_r ? (sec_q_r & ~sec_now) : (~sec_q_r & sec_now);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            {sel_r, fall_r, on_q_r, pri_q_r, sec_q_r} <= '0;
        else
        begin
            if (reg_wr && reg_addr == pdt_pkg::OFS_SEL)
                sel_r <= reg_wdata;
            if (reg_wr && reg_addr == pdt_pkg::OFS_CTRL)
                fall_r <= reg_wdata[1];
            if (scan_en)
                {on_q_r, pri_q_r, sec_q_r} <= {on_lr, cnt_lr, sec_now};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_on_rise_waits: assert property (scan_en && on_lr && !on_q_r |=> !on_delay_timer_out)
        else $error("on-delay output set at the starting scan");
    a_on_drops_low: assert property (scan_en && !on_lr |=> !on_delay_timer_out)
        else $error("on-delay output held with result low");
    a_on_needs_high: assert property ($rose(on_delay_timer_out) && !$past(srst) |-> on_q_r)
        else $error("on-delay output rose without a high result");
    a_on_scan_only: assert property ($changed(on_delay_timer_out) && !$past(srst) |-> $past(scan_en))
        else $error("on-delay output moved outside a scan");
    a_off_sets_now: assert property (scan_en && off_lr |=> latching_off_delay_timer_out)
        else $error("off-delay output not set by a high result");
    a_off_clears_low: assert property ($fell(latching_off_delay_timer_out) && !$past(srst)
        |-> $past(scan_en) && !$past(off_lr)) else $error("off-delay output cleared with result high");
    a_cnt_set_edge: assert property ($rose(cnt_out) && !$past(srst)
        |-> $past(scan_en) && $past(pri_edge))
        else $error("counter output set without a primary edge");
    a_cnt_sec_quits: assert property (scan_en && sec_edge && !pri_edge |=> !cnt_out)
        else $error("counter output kept after a second-condition edge");
    a_cnt_rst_drops: assert property (scan_en && rst_now |=> !cnt_out)
        else $error("counter output kept during reset condition");
endmodule // pdt_checker

bind pdt_top pdt_checker #(.IDX_W(IDX_W)) u_pdt_checker (.sys_clk(sys_clk), .srst(srst), .scan_en(scan_en),
    .on_lr(on_lr), .off_lr(off_lr), .cnt_lr(cnt_lr), .sig_ranges(sig_ranges), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .on_delay_timer_out(on_delay_timer_out), .latching_off_delay_timer_out(latching_off_delay_timer_out),
    .cnt_out(cnt_out));

/* File: sim/pdt_ladder_model.sv */
// Ladder network model feeding scans, logic results and signal ranges
`timescale 1ns/1ps
module pdt_ladder_model #(
    parameter int unsigned SCAN_PER = 10
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [4:0]  req,
    input  wire logic [10:0] sec_pos,
    input  wire logic [10:0] rst_pos,
    output logic             scan_en,
    output logic             on_lr,
    output logic             off_lr,
    output logic             cnt_lr,
    output logic [2047:0]    sig_ranges
);
    int unsigned   cyc_r = 0;
    logic          sec_r, rst_r;
    logic [2047:0] pat;

    initial
        {scan_en, on_lr, off_lr, cnt_lr, sec_r, rst_r, sig_ranges} = '0;

    // Unselected signals churn every cycle so a wrong pick shows up
    always @(posedge sys_clk)
    begin
        pat = {64{$urandom}};
        pat[sec_pos] = sec_r;
        pat[rst_pos] = rst_r;
        sig_ranges <= pat;
        cyc_r <= (srst || cyc_r == SCAN_PER - 1) ? 0 : cyc_r + 1;
        scan_en <= !srst && cyc_r == SCAN_PER - 1;
        // Results move only on a scan boundary, like a real ladder pass
        if (scan_en)
            {rst_r, sec_r, cnt_lr, off_lr, on_lr} <= {req[2], req[1], req[0], req[4], req[3]};
    end
endmodule // pdt_ladder_model

/* File: sim/plc_delay_timers_and_updown_counters_tb.sv */
// Self-checking bench for the timer and counter block
`timescale 1ns/1ps
module plc_delay_timers_and_updown_counters_tb;
    logic          sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic [7:0]    reg_addr = 8'h00;
    logic [31:0]   reg_wdata = 32'h0, reg_rdata;
    logic [4:0]    req = 5'h00;
    logic [10:0]   sec_pos = 11'h000, rst_pos = 11'h001;
    logic          scan_en, on_lr, off_lr, cnt_lr, on_out, off_out, cnt_out;
    logic [2047:0] sig_ranges;
    logic [31:0]   exp_q[$];
    logic [2:0]    code;
    int            mismatches = 0, tests_run = 0;

    pdt_top #(.TICK_CYCLES(4)) uut (.sys_clk(sys_clk), .srst(srst), .scan_en(scan_en), .on_lr(on_lr),
        .off_lr(off_lr), .cnt_lr(cnt_lr), .sig_ranges(sig_ranges), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .on_delay_timer_out(on_out),
        .latching_off_delay_timer_out(off_out), .cnt_out(cnt_out));
    pdt_ladder_model u_ladder (.sys_clk(sys_clk), .srst(srst), .req(req), .sec_pos(sec_pos), .rst_pos(rst_pos),
        .scan_en(scan_en), .on_lr(on_lr), .off_lr(off_lr), .cnt_lr(cnt_lr), .sig_ranges(sig_ranges));

    initial
        forever #10 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Bus cycles, scan pacing and result checking
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A read notes its expected word; the monitor compares it a cycle later
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= rd;
        reg_wr <= !rd;
        reg_addr <= a;
        reg_wdata <= d;
        if (rd)
            exp_q.push_back(d);
        @(posedge sys_clk);
        {reg_rd, reg_wr} <= 2'b00;
    endtask

    task automatic wait_scans(input int n);
        repeat (n) @(posedge sys_clk iff scan_en);
        repeat (2) @(posedge sys_clk);
    endtask

    // High for two scans then low for two: one rising and one falling edge
    task automatic pulse(input int b);
        req[b] <= 1'b1;
        wait_scans(2);
        req[b] <= 1'b0;
        wait_scans(2);
    endtask

    always @(posedge sys_clk)
    begin
        if (rd_seen)
            check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXXXXXX);
        rd_seen <= reg_rd;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h1687));
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        code = 3'($urandom_range(7));
        sec_pos <= {code, 8'($urandom)};
        rst_pos <= {code ^ 3'h1, 8'($urandom)};
        // Positions must settle before the select word is built
        @(posedge sys_clk);
        bus(1'b0, pdt_pkg::OFS_SEL, {1'b0, rst_pos[10:8], 4'h0, rst_pos[7:0], 1'b0, sec_pos[10:8], 4'h0, sec_pos[7:0]});
        bus(1'b0, pdt_pkg::OFS_TMR_PRE, 32'h8);
        req[3] <= 1'b1;
        wait_scans(3);
        req[3] <= 1'b0;
        wait_scans(2);
        req[3] <= 1'b1;
        wait_scans(3);
        bus(1'b1, pdt_pkg::OFS_STATUS, 32'h0);
        wait_scans(4);
        bus(1'b1, pdt_pkg::OFS_STATUS, 32'h1);
        req[3] <= 1'b0;
        wait_scans(2);
        bus(1'b1, pdt_pkg::OFS_STATUS, 32'h0);
        req[4] <= 1'b1;
        wait_scans(2);
        bus(1'b1, pdt_pkg::OFS_STATUS, 32'h2);
        req[4] <= 1'b0;
        wait_scans(3);
        bus(1'b1, pdt_pkg::OFS_STATUS, 32'h2);
        wait_scans(4);
        bus(1'b1, pdt_pkg::OFS_STATUS, 32'h0);
        bus(1'b0, pdt_pkg::OFS_CNT_PRE, 32'h3);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b0, pdt_pkg::OFS_CTRL, 32'(m));
            bus(1'b0, pdt_pkg::OFS_CNT_CLR, 32'h0);
            wait_scans(1);
            repeat (3) pulse(0);
            bus(1'b1, pdt_pkg::OFS_COUNT, m[0] ? 32'h0 : 32'h3);
            bus(1'b1, pdt_pkg::OFS_STATUS, 32'h4);
            pulse(1);
            bus(1'b1, pdt_pkg::OFS_STATUS, 32'h0);
            bus(1'b1, pdt_pkg::OFS_COUNT, m[0] ? 32'h1 : 32'h2);
            pulse(2);
            bus(1'b1, pdt_pkg::OFS_COUNT, m[0] ? 32'h3 : 32'h0);
            pulse(1);
            bus(1'b1, pdt_pkg::OFS_COUNT, m[0] ? 32'h4 : 32'hFFFFFFFF);
        end
        bus(1'b0, pdt_pkg::OFS_CNT_PRE, 32'hFFFFFFFF);
        bus(1'b0, pdt_pkg::OFS_CTRL, 32'h1);
        bus(1'b0, pdt_pkg::OFS_CNT_CLR, 32'h0);
        wait_scans(1);
        bus(1'b1, pdt_pkg::OFS_COUNT, 32'h0098967F);
        bus(1'b0, pdt_pkg::OFS_TMR_PRE, 32'hFFFFFFFF);
        bus(1'b1, pdt_pkg::OFS_TMR_PRE, 32'h0000FFEF);
        bus(1'b1, 8'h1C, 32'h0);
        repeat (2) @(posedge sys_clk);
        complete_run();
    end
endmodule // plc_delay_timers_and_updown_counters_tb
